// File: hdl/hv_prog_device.sv
// Behaviour
// - Programmer holds entry selects zero 10 us
// - Programmer waits 300 us before commands
// - Leave programming mode when high voltage drops
// - Command and address persist across operations
// - Programmer reloads high address per window
// - Erase memories, then lock bits; fuses kept
// - Preserve fuse keeps data memory on erase
// - Select 10, byte select low loads command
// - Write strobe starts operation, busy goes low
// - Command 10h enables flash page programming
// - Select 00 loads low or high address
// - Select 01 loads low or high data
// - Page latch stores data at low address
// - Low bits word, high bits page
// - Write strobe programs whole flash page, busy
// - Command 00h is no-op, clears write enable
// - Command 11h writes data memory page
// - Command 02h reads flash low/high byte
// - Command 03h reads data memory byte
// - Command 40h writes fuse low bits
// - Programmer erases chip before reprogramming
// - Ready low while busy, high when ready
// - Drive data bus only while output enable low
`timescale 1ns/1ns
`include "hv_prog_cfg.svh"

module hv_prog_device
  import hv_prog_pkg::*;
#(
  parameter int FLASH_AW = 14,
  parameter int FLASH_PW = 6,
  parameter int EE_AW = 10,
  parameter int EE_PW = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  hv_prog_if.device pins,
  input wire logic preserve_data_mem_fuse,
  output logic prog_mode,
  output logic [7:0] fuse_low,
  output logic [7:0] lock_bits,
  output logic sram_clear
);

  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int EE_BYTES = 1 << EE_AW;
  localparam int FPAGE = 1 << FLASH_PW;
  localparam int EPAGE = 1 << EE_PW;

  initial
  begin
    if (FLASH_AW > 16 || EE_AW > 16 || EE_AW > FLASH_AW || FLASH_PW > 8 || EE_PW > 8 || FLASH_PW < 1 || EE_PW < 1
        || FLASH_PW >= FLASH_AW || EE_PW >= EE_AW)
      $error("hv_prog_device: address widths out of range");
  end

  logic [15:0] flash_mem [0:FLASH_WORDS-1];
  logic [7:0] ee_mem [0:EE_BYTES-1];
  logic [15:0] flash_buf [0:FPAGE-1];
  logic [7:0] ee_buf [0:EPAGE-1];

  logic [16:0] s_lvl;
  logic [16:0] s_rise;
  logic [16:0] s_fall;

  pin_sync_edge #(.WIDTH(17)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({pins.hv_applied, pins.action_select_hi, pins.action_select_lo, pins.byte_select_one,
             pins.byte_select_two, pins.page_latch_strobe, pins.load_strobe, pins.write_strobe_n,
             pins.out_enable_n, pins.data_bus}),
    .level(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );

  logic hv_lvl;
  logic [1:0] action_sel;
  logic bs1;
  logic bs2;
  logic page_latch_rise;
  logic load_rise;
  logic write_fall;
  logic oe_n_lvl;
  logic [7:0] data_in;

  assign hv_lvl = s_lvl[16];
  assign action_sel = s_lvl[15:14];
  assign bs1 = s_lvl[13];
  assign bs2 = s_lvl[12];
  assign page_latch_rise = s_rise[11];
  assign load_rise = s_rise[10];
  assign write_fall = s_fall[9];
  assign oe_n_lvl = s_lvl[8];
  assign data_in = s_lvl[7:0];

  dev_state_e state_r;
  logic [15:0] cnt_r;
  logic [15:0] wait_len_r;
  logic [7:0] cmd_r;
  logic write_en_r;
  logic [7:0] addr_lo_r;
  logic [7:0] addr_hi_r;
  logic [7:0] data_lo_r;
  logic [7:0] data_hi_r;
  logic [7:0] dout_r;
  logic dout_oe_n_r;
  logic ready_r;
  logic in_mode;
  logic accept;

  logic [FLASH_AW-1:0] flash_addr;
  logic [FLASH_AW-1:0] flash_page_addr;
  logic [EE_AW-1:0] ee_addr;
  logic [EE_AW-1:0] ee_page_addr;
  logic copy_flash;
  logic [15:0] copy_last;

  assign in_mode = (state_r != ST_OFF) && (state_r != ST_ENTRY);
  assign accept = (state_r == ST_IDLE);
  assign flash_addr = FLASH_AW'({addr_hi_r, addr_lo_r});
  assign ee_addr = EE_AW'({addr_hi_r, addr_lo_r});
  // Page bits come from the loaded address, word bits from the copy count
  assign flash_page_addr = {flash_addr[FLASH_AW-1:FLASH_PW], cnt_r[FLASH_PW-1:0]};
  assign ee_page_addr = {ee_addr[EE_AW-1:EE_PW], cnt_r[EE_PW-1:0]};
  assign copy_flash = (cmd_r == `CMD_WR_FLASH);
  assign copy_last = copy_flash ? 16'(FPAGE - 1) : 16'(EPAGE - 1);

  // Mode entry, exit and operation sequencing
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_OFF;
      cnt_r <= 16'h0000;
      wait_len_r <= 16'h0000;
    end
    else if (!hv_lvl)
    begin
      state_r <= ST_OFF;
      cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_OFF:
        begin
          // Entry is only accepted on the voltage edge; the pattern is checked again through the hold
          if (s_rise[16] && !s_lvl[11] && action_sel == 2'h0 && !bs1)
          begin
            state_r <= ST_ENTRY;
            cnt_r <= 16'h0000;
          end
        end
        ST_ENTRY:
        begin
          if (s_lvl[11] || action_sel != 2'h0 || bs1)
            state_r <= ST_OFF;
          else if (cnt_r == 16'(`ENTRY_HOLD_CYC - 1))
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_IDLE:
        begin
          cnt_r <= 16'h0000;
          if (write_fall)
          begin
            if (cmd_r == `CMD_ERASE)
              state_r <= ST_ERASE;
            else if (write_en_r && (copy_flash || !bs1))
              state_r <= ST_COPY;
            else if (cmd_r == `CMD_WR_FUSE && !bs1 && !bs2)
            begin
              state_r <= ST_WAIT;
              wait_len_r <= 16'(`FUSE_PROG_CYC);
            end
          end
        end
        ST_ERASE:
        begin
          if (cnt_r == 16'(FLASH_WORDS - 1))
          begin
            state_r <= ST_WAIT;
            cnt_r <= 16'h0000;
            wait_len_r <= 16'(`ERASE_CYC);
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_COPY:
        begin
          if (cnt_r == copy_last)
          begin
            state_r <= ST_WAIT;
            cnt_r <= 16'h0000;
            wait_len_r <= 16'(`PAGE_PROG_CYC);
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_WAIT:
        begin
          if (cnt_r >= wait_len_r - 16'h0001)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        default:
          state_r <= ST_OFF;
      endcase
    end
  end

  // Address and data latches persist until reloaded; command and write enable clear outside the mode
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmd_r <= `CMD_NOP;
      write_en_r <= 1'b0;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      data_lo_r <= 8'h00;
      data_hi_r <= 8'h00;
    end
    else if (!in_mode)
    begin
      cmd_r <= `CMD_NOP;
      write_en_r <= 1'b0;
    end
    else if (accept && load_rise)
    begin
      if (action_sel == `XA_CMD && !bs1)
      begin
        cmd_r <= data_in;
        // No-op and every non-write command drop the write enable
        write_en_r <= (data_in == `CMD_WR_FLASH) || (data_in == `CMD_WR_EE);
      end
      else if (action_sel == `XA_ADDR)
      begin
        if (bs1)
          addr_hi_r <= data_in;
        else
          addr_lo_r <= data_in;
      end
      else if (action_sel == `XA_DATA)
      begin
        if (bs1)
          data_hi_r <= data_in;
        else
          data_lo_r <= data_in;
      end
    end
  end

  // Page buffers and arrays; arrays hold no reset, erase defines them unless the preserve fuse keeps data memory
  always_ff @(posedge clk_sys)
  begin
    if (accept && page_latch_rise && write_en_r)
    begin
      if (copy_flash)
        flash_buf[addr_lo_r[FLASH_PW-1:0]] <= {data_hi_r, data_lo_r};
      else
        ee_buf[addr_lo_r[EE_PW-1:0]] <= data_lo_r;
    end
    else if (state_r == ST_ERASE)
    begin
      flash_mem[cnt_r[FLASH_AW-1:0]] <= `ERASED_WORD;
      // Buffers power up unknown; unlatched words must program as erased
      flash_buf[cnt_r[FLASH_PW-1:0]] <= `ERASED_WORD;
      ee_buf[cnt_r[EE_PW-1:0]] <= `ERASED_BYTE;
      if (!preserve_data_mem_fuse && cnt_r < 16'(EE_BYTES))
        ee_mem[cnt_r[EE_AW-1:0]] <= `ERASED_BYTE;
    end
    else if (state_r == ST_COPY)
    begin
      if (copy_flash)
      begin
        flash_mem[flash_page_addr] <= flash_buf[cnt_r[FLASH_PW-1:0]];
        flash_buf[cnt_r[FLASH_PW-1:0]] <= `ERASED_WORD;
      end
      else
      begin
        ee_mem[ee_page_addr] <= ee_buf[cnt_r[EE_PW-1:0]];
        ee_buf[cnt_r[EE_PW-1:0]] <= `ERASED_BYTE;
      end
    end
  end

  // Fuse and lock state
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fuse_low <= `FUSE_LOW_RST;
      lock_bits <= `LOCK_RST;
      sram_clear <= 1'b0;
    end
    else
    begin
      sram_clear <= (state_r == ST_IDLE) && write_fall && (cmd_r == `CMD_ERASE);
      if (accept && write_fall && cmd_r == `CMD_WR_FUSE && !bs1 && !bs2)
        fuse_low <= data_lo_r;
      // Locks clear on the same edge that erases the last flash word
      if (state_r == ST_ERASE && cnt_r == 16'(FLASH_WORDS - 1))
        lock_bits <= `LOCK_RST;
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dout_r <= `BUS_IDLE;
      dout_oe_n_r <= 1'b1;
      ready_r <= 1'b1;
      prog_mode <= 1'b0;
    end
    else
    begin
      prog_mode <= in_mode;
      ready_r <= !(state_r == ST_ERASE || state_r == ST_COPY || state_r == ST_WAIT);
      dout_oe_n_r <= !(in_mode && !oe_n_lvl);
      if (cmd_r == `CMD_RD_FLASH)
        dout_r <= bs1 ? flash_mem[flash_addr][15:8] : flash_mem[flash_addr][7:0];
      else if (cmd_r == `CMD_RD_EE && !bs1)
        dout_r <= ee_mem[ee_addr];
      else if (cmd_r == `CMD_RD_FUSE && !bs2)
        dout_r <= bs1 ? lock_bits : fuse_low;
      else
        dout_r <= `BUS_IDLE;
    end
  end

  assign pins.dev_data_out = dout_r;
  assign pins.dev_data_oe_n = dout_oe_n_r;
  assign pins.ready_busy_out = ready_r;

endmodule

// File: hdl/hv_prog_cfg.svh
`ifndef HV_PROG_CFG_SVH
`define HV_PROG_CFG_SVH

`define CLK_MHZ 10

// Strobe width and timing figures, each followed by its cycle count; the last two are cycle counts only
`define PULSE_NS 250
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define ENTRY_HOLD_US 10
`define ENTRY_HOLD_CYC (`ENTRY_HOLD_US * `CLK_MHZ)
`define CMD_WAIT_US 300
`define CMD_WAIT_CYC (`CMD_WAIT_US * `CLK_MHZ)
`define PAGE_PROG_US 100
`define PAGE_PROG_CYC (`PAGE_PROG_US * `CLK_MHZ)
`define ERASE_US 200
`define ERASE_CYC (`ERASE_US * `CLK_MHZ)
`define FUSE_PROG_US 50
`define FUSE_PROG_CYC (`FUSE_PROG_US * `CLK_MHZ)
`define ACK_TIMEOUT_CYC 16
`define READ_SETTLE_CYC 8

// Action select coding
`define XA_ADDR 2'h0
`define XA_DATA 2'h1
`define XA_CMD 2'h2
`define XA_IDLE 2'h3

// Command bytes
`define CMD_NOP 8'h00
`define CMD_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EE 8'h11
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EE 8'h03

// Reset and erased values
`define ERASED_WORD 16'hFFFF
`define ERASED_BYTE 8'hFF
`define FUSE_LOW_RST 8'hFF
`define LOCK_RST 8'hFF
`define BUS_IDLE 8'hFF

`endif

// File: hdl/hv_prog_pkg.sv
package hv_prog_pkg;

  typedef enum logic [2:0] {ST_OFF, ST_ENTRY, ST_IDLE, ST_ERASE, ST_COPY, ST_WAIT} dev_state_e;

  typedef enum logic [2:0] {OP_ENTER, OP_EXIT, OP_LOAD_CMD, OP_LOAD_ADDR, OP_LOAD_DATA, OP_PAGE_LATCH,
                            OP_WRITE, OP_READ} host_op_e;

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_PULSE, H_HOLD, H_ACK, H_BUSY, H_ENTRY, H_SETTLE} host_state_e;

endpackage

// File: hdl/hv_prog_if.sv
`timescale 1ns/1ns
`include "hv_prog_cfg.svh"

interface hv_prog_if;
  logic hv_applied;
  logic action_select_hi;
  logic action_select_lo;
  logic byte_select_one;
  logic byte_select_two;
  logic page_latch_strobe;
  logic load_strobe;
  logic write_strobe_n;
  logic out_enable_n;
  logic [7:0] host_data_out;
  logic host_data_oe_n;
  logic [7:0] dev_data_out;
  logic dev_data_oe_n;
  logic ready_busy_out;
  logic [7:0] data_bus;

  // Wire level; an undriven bus floats high
  assign data_bus = !dev_data_oe_n ? dev_data_out : (!host_data_oe_n ? host_data_out : `BUS_IDLE);

  modport device (
    input hv_applied, action_select_hi, action_select_lo, byte_select_one, byte_select_two,
    input page_latch_strobe, load_strobe, write_strobe_n, out_enable_n, data_bus,
    output dev_data_out, dev_data_oe_n, ready_busy_out
  );

  modport host (
    output hv_applied, action_select_hi, action_select_lo, byte_select_one, byte_select_two,
    output page_latch_strobe, load_strobe, write_strobe_n, out_enable_n, host_data_out, host_data_oe_n,
    input data_bus, ready_busy_out
  );
endinterface

// File: hdl/pin_sync_edge.sv
`timescale 1ns/1ns

module pin_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync_edge: WIDTH must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      logic prev_r;
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin_in[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      // Edges compare the second and third stages only
      assign level[i] = sync_r;
      assign rise[i] = sync_r & ~prev_r;
      assign fall[i] = ~sync_r & prev_r;
    end
  endgenerate

endmodule

// File: hdl/hv_prog_host.sv
`timescale 1ns/1ns
`include "hv_prog_cfg.svh"

module hv_prog_host
  import hv_prog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  hv_prog_if.host pins,
  input wire logic req_valid,
  input wire host_op_e req_op,
  input wire logic [7:0] req_data,
  input wire logic req_bs1,
  input wire logic req_bs2,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);

  logic [8:0] s_lvl;

  pin_sync_edge #(.WIDTH(9)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({pins.ready_busy_out, pins.data_bus}),
    .level(s_lvl),
    .rise(),
    .fall()
  );

  host_state_e state_r;
  host_op_e op_r;
  logic [11:0] cnt_r;
  logic hv_r;
  logic [1:0] xa_r;
  logic bs1_r;
  logic bs2_r;
  logic page_latch_strobe_r;
  logic load_r;
  logic wr_n_r;
  logic oe_n_r;
  logic [7:0] dout_r;
  logic drive_n_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= H_IDLE;
      op_r <= OP_ENTER;
      cnt_r <= 12'h000;
      hv_r <= 1'b0;
      xa_r <= `XA_IDLE;
      bs1_r <= 1'b0;
      bs2_r <= 1'b0;
      page_latch_strobe_r <= 1'b0;
      load_r <= 1'b0;
      wr_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      dout_r <= 8'h00;
      drive_n_r <= 1'b1;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_r)
        H_IDLE:
        begin
          cnt_r <= 12'h000;
          if (req_valid)
          begin
            req_ready <= 1'b0;
            op_r <= req_op;
            bs1_r <= req_bs1;
            bs2_r <= req_bs2;
            dout_r <= req_data;
            drive_n_r <= (req_op == OP_READ);
            state_r <= H_SETUP;
            case (req_op)
              OP_ENTER:
              begin
                // Entry pattern is action selects and byte select one low; byte select two follows the request
                xa_r <= `XA_ADDR;
                bs1_r <= 1'b0;
                hv_r <= 1'b0;
              end
              OP_LOAD_CMD:
              begin
                xa_r <= `XA_CMD;
                bs1_r <= 1'b0;
              end
              OP_LOAD_ADDR:
                xa_r <= `XA_ADDR;
              OP_LOAD_DATA:
                xa_r <= `XA_DATA;
              default:
                xa_r <= `XA_IDLE;
            endcase
          end
        end
        H_SETUP:
        begin
          if (cnt_r == 12'(`PULSE_CYC - 1))
          begin
            cnt_r <= 12'h000;
            case (op_r)
              OP_ENTER:
              begin
                hv_r <= 1'b1;
                state_r <= H_ENTRY;
              end
              OP_EXIT:
              begin
                hv_r <= 1'b0;
                state_r <= H_HOLD;
              end
              OP_READ:
              begin
                oe_n_r <= 1'b0;
                state_r <= H_SETTLE;
              end
              default:
              begin
                load_r <= (op_r == OP_LOAD_CMD) || (op_r == OP_LOAD_ADDR) || (op_r == OP_LOAD_DATA);
                page_latch_strobe_r <= (op_r == OP_PAGE_LATCH);
                wr_n_r <= (op_r != OP_WRITE);
                state_r <= H_PULSE;
              end
            endcase
          end
          else
            cnt_r <= cnt_r + 12'h001;
        end
        H_PULSE:
        begin
          if (cnt_r == 12'(`PULSE_CYC - 1))
          begin
            cnt_r <= 12'h000;
            load_r <= 1'b0;
            page_latch_strobe_r <= 1'b0;
            wr_n_r <= 1'b1;
            state_r <= (op_r == OP_WRITE) ? H_ACK : H_HOLD;
          end
          else
            cnt_r <= cnt_r + 12'h001;
        end
        H_ACK:
        begin
          // Operations that start nothing never drop ready
          if (!s_lvl[8] || cnt_r == 12'(`ACK_TIMEOUT_CYC - 1))
          begin
            cnt_r <= 12'h000;
            state_r <= H_BUSY;
          end
          else
            cnt_r <= cnt_r + 12'h001;
        end
        H_BUSY:
        begin
          if (s_lvl[8])
            state_r <= H_HOLD;
        end
        H_ENTRY:
        begin
          // Selects stay low through the hold and the settling wait
          if (cnt_r == 12'(`ENTRY_HOLD_CYC + `CMD_WAIT_CYC - 1))
          begin
            cnt_r <= 12'h000;
            xa_r <= `XA_IDLE;
            state_r <= H_HOLD;
          end
          else
            cnt_r <= cnt_r + 12'h001;
        end
        H_SETTLE:
        begin
          if (cnt_r == 12'(`READ_SETTLE_CYC - 1))
          begin
            cnt_r <= 12'h000;
            rsp_valid <= 1'b1;
            rsp_data <= s_lvl[7:0];
            oe_n_r <= 1'b1;
            state_r <= H_HOLD;
          end
          else
            cnt_r <= cnt_r + 12'h001;
        end
        H_HOLD:
        begin
          if (cnt_r == 12'(`PULSE_CYC - 1))
          begin
            cnt_r <= 12'h000;
            req_ready <= 1'b1;
            state_r <= H_IDLE;
          end
          else
            cnt_r <= cnt_r + 12'h001;
        end
        default:
          state_r <= H_IDLE;
      endcase
    end
  end

  assign pins.hv_applied = hv_r;
  assign pins.action_select_hi = xa_r[1];
  assign pins.action_select_lo = xa_r[0];
  assign pins.byte_select_one = bs1_r;
  assign pins.byte_select_two = bs2_r;
  assign pins.page_latch_strobe = page_latch_strobe_r;
  assign pins.load_strobe = load_r;
  assign pins.write_strobe_n = wr_n_r;
  assign pins.out_enable_n = oe_n_r;
  assign pins.host_data_out = dout_r;
  assign pins.host_data_oe_n = drive_n_r;

endmodule

// File: verif/hv_prog_chk_sva.sv
`timescale 1ns/1ns
`include "hv_prog_cfg.svh"

module hv_prog_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hv_applied,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic byte_select_one,
  input wire logic page_latch_strobe,
  input wire logic load_strobe,
  input wire logic write_strobe_n,
  input wire logic out_enable_n,
  input wire logic dev_data_oe_n,
  input wire logic ready_busy_out
);
  localparam int WAIT_CYC = `CMD_WAIT_CYC;
  logic [11:0] mode_cnt_r;
  logic [11:0] busy_cnt_r;
  logic [3:0] sel;

  assign sel = {page_latch_strobe, action_select_hi, action_select_lo, byte_select_one};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Saturating; only has to reach the command wait
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_cnt_r <= 12'h000;
    else if (!hv_applied)
      mode_cnt_r <= 12'h000;
    else if (mode_cnt_r != 12'hFFF)
      mode_cnt_r <= mode_cnt_r + 12'h001;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      busy_cnt_r <= 12'h000;
    else if (ready_busy_out)
      busy_cnt_r <= 12'h000;
    else if (busy_cnt_r != 12'hFFF)
      busy_cnt_r <= busy_cnt_r + 12'h001;
  end

  sequence s_pulse;
    load_strobe [*3] ##1 !load_strobe;
  endsequence
  sequence s_sel_hold;
    $stable(sel) [*4];
  endsequence
  sequence s_entry;
    (sel == 4'h0) [*8];
  endsequence

  property p_entry;
    $rose(hv_applied) |-> s_entry;
  endproperty
  a_entry: assert property (p_entry) else $error("entry pattern not held");
  property p_wait;
    $rose(load_strobe) |-> mode_cnt_r >= WAIT_CYC;
  endproperty
  a_wait: assert property (p_wait) else $error("load before entry wait");
  property p_exit;
    !hv_applied [*5] |-> dev_data_oe_n && ready_busy_out;
  endproperty
  a_exit: assert property (p_exit) else $error("active outside mode");
  property p_strobe;
    $rose(load_strobe) |-> s_pulse;
  endproperty
  a_strobe: assert property (p_strobe) else $error("load pulse width");
  property p_sel;
    $rose(load_strobe) |-> s_sel_hold;
  endproperty
  a_sel: assert property (p_sel) else $error("selects moved under load");
  property p_busy_start;
    $fell(write_strobe_n) |-> ##[1:8] !ready_busy_out;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("no busy after write");
  property p_busy_hold;
    $fell(ready_busy_out) |=> !ready_busy_out [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_busy_max;
    busy_cnt_r <= 12'h960;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_oe_on;
    $fell(out_enable_n) |-> ##[1:8] !dev_data_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not driven");
  property p_oe_off;
    out_enable_n [*6] |-> dev_data_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven without enable");
endmodule

// File: verif/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
  import hv_prog_pkg::*;
  typedef struct packed {host_op_e o; logic [7:0] d; logic b1; logic [7:0] e;} row_s;
  logic clk_sys, rst, req_valid, req_bs1, req_bs2, req_ready, rsp_valid;
  logic preserve, prog_mode, sram_clear;
  host_op_e req_op;
  logic [7:0] req_data, rsp_data, fuse_low, lock_bits, r;
  int mismatches, comparisons, cyc, erases;
  row_s rows[] = '{
    '{OP_ENTER, 8'h00, 1'b0, 8'h00},
    '{OP_LOAD_CMD, 8'h80, 1'b0, 8'h00}, '{OP_WRITE, 8'h00, 1'b0, 8'h00},
    '{OP_LOAD_CMD, 8'h10, 1'b0, 8'h00}, '{OP_LOAD_ADDR, 8'h41, 1'b0, 8'h00},
    '{OP_LOAD_DATA, 8'h34, 1'b0, 8'h00}, '{OP_LOAD_DATA, 8'h12, 1'b1, 8'h00},
    '{OP_PAGE_LATCH, 8'h00, 1'b1, 8'h00}, '{OP_LOAD_ADDR, 8'h7F, 1'b0, 8'h00},
    '{OP_LOAD_DATA, 8'h78, 1'b0, 8'h00}, '{OP_LOAD_DATA, 8'h56, 1'b1, 8'h00},
    '{OP_PAGE_LATCH, 8'h00, 1'b1, 8'h00}, '{OP_LOAD_ADDR, 8'h00, 1'b1, 8'h00},
    '{OP_WRITE, 8'h00, 1'b0, 8'h00}, '{OP_LOAD_CMD, 8'h00, 1'b0, 8'h00},
    '{OP_LOAD_CMD, 8'h02, 1'b0, 8'h00}, '{OP_LOAD_ADDR, 8'h41, 1'b0, 8'h00},
    '{OP_READ, 8'h00, 1'b0, 8'h34}, '{OP_READ, 8'h00, 1'b1, 8'h12},
    '{OP_LOAD_ADDR, 8'h7F, 1'b0, 8'h00}, '{OP_READ, 8'h00, 1'b0, 8'h78},
    '{OP_READ, 8'h00, 1'b1, 8'h56}, '{OP_LOAD_ADDR, 8'h40, 1'b0, 8'h00},
    '{OP_READ, 8'h00, 1'b0, 8'hFF},
    '{OP_LOAD_CMD, 8'h11, 1'b0, 8'h00}, '{OP_LOAD_ADDR, 8'h05, 1'b0, 8'h00},
    '{OP_LOAD_DATA, 8'h5A, 1'b0, 8'h00}, '{OP_PAGE_LATCH, 8'h00, 1'b0, 8'h00},
    '{OP_WRITE, 8'h00, 1'b0, 8'h00}, '{OP_LOAD_CMD, 8'h03, 1'b0, 8'h00},
    '{OP_READ, 8'h00, 1'b0, 8'h5A}, '{OP_LOAD_ADDR, 8'h06, 1'b0, 8'h00},
    '{OP_READ, 8'h00, 1'b0, 8'hFF}, '{OP_LOAD_CMD, 8'h40, 1'b0, 8'h00},
    '{OP_LOAD_DATA, 8'hA5, 1'b0, 8'h00}, '{OP_WRITE, 8'h00, 1'b0, 8'h00},
    '{OP_LOAD_CMD, 8'h04, 1'b0, 8'h00}, '{OP_READ, 8'h00, 1'b0, 8'hA5},
    '{OP_READ, 8'h00, 1'b1, 8'hFF}
  };

  hv_prog_if i_hv_prog_if ();
  hv_prog_device #(.FLASH_AW(8), .FLASH_PW(6), .EE_AW(6), .EE_PW(2)) i_hv_prog_device (
    .clk_sys(clk_sys), .rst(rst), .pins(i_hv_prog_if), .preserve_data_mem_fuse(preserve),
    .prog_mode(prog_mode), .fuse_low(fuse_low), .lock_bits(lock_bits), .sram_clear(sram_clear));
  hv_prog_host i_hv_prog_host (
    .clk_sys(clk_sys), .rst(rst), .pins(i_hv_prog_if), .req_valid(req_valid), .req_op(req_op),
    .req_data(req_data), .req_bs1(req_bs1), .req_bs2(req_bs2), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  hv_prog_chk i_hv_prog_chk (
    .clk_sys(clk_sys), .rst(rst), .hv_applied(i_hv_prog_if.hv_applied),
    .action_select_hi(i_hv_prog_if.action_select_hi), .action_select_lo(i_hv_prog_if.action_select_lo),
    .byte_select_one(i_hv_prog_if.byte_select_one), .page_latch_strobe(i_hv_prog_if.page_latch_strobe),
    .load_strobe(i_hv_prog_if.load_strobe), .write_strobe_n(i_hv_prog_if.write_strobe_n),
    .out_enable_n(i_hv_prog_if.out_enable_n), .dev_data_oe_n(i_hv_prog_if.dev_data_oe_n),
    .ready_busy_out(i_hv_prog_if.ready_busy_out));

  task end_sim;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Caller enters just after an edge with the host idle
  task automatic op(input host_op_e o, input logic [7:0] d, input logic b1);
    req_op = o;
    req_data = d;
    req_bs1 = b1;
    req_valid = 1'b1;
    r = 8'hXX;
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    while (req_ready !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
      if (rsp_valid === 1'b1)
        r = rsp_data;
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Generous ceiling; the whole run needs about 13000 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (sram_clear === 1'b1)
      erases++;
    if (cyc == 30000)
    begin
      mismatches++;
      end_sim;
    end
  end

  initial
  begin
    {rst, req_valid, req_bs1, req_bs2, preserve} = 5'h10;
    req_op = OP_ENTER;
    req_data = 8'h00;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    `CHK(i_hv_prog_if.ready_busy_out, 1'b1)
    `CHK(i_hv_prog_if.dev_data_oe_n, 1'b1)
    `CHK({req_ready, prog_mode, lock_bits}, 10'h2FF)
    foreach (rows[i])
    begin
      op(rows[i].o, rows[i].d, rows[i].b1);
      if (rows[i].o == OP_READ)
        `CHK(r, rows[i].e)
    end
    `CHK(fuse_low, 8'hA5)
    preserve = 1'b1;
    op(OP_LOAD_CMD, 8'h80, 1'b0);
    op(OP_WRITE, 8'h00, 1'b0);
    op(OP_LOAD_CMD, 8'h03, 1'b0);
    op(OP_LOAD_ADDR, 8'h05, 1'b0);
    op(OP_READ, 8'h00, 1'b0);
    `CHK(r, 8'h5A)
    op(OP_LOAD_CMD, 8'h02, 1'b0);
    op(OP_LOAD_ADDR, 8'h41, 1'b0);
    op(OP_READ, 8'h00, 1'b1);
    `CHK(r, 8'hFF)
    `CHK({fuse_low, lock_bits}, 16'hA5FF)
    preserve = 1'b0;
    op(OP_LOAD_CMD, 8'h80, 1'b0);
    op(OP_WRITE, 8'h00, 1'b0);
    op(OP_LOAD_CMD, 8'h03, 1'b0);
    op(OP_LOAD_ADDR, 8'h05, 1'b0);
    op(OP_READ, 8'h00, 1'b0);
    `CHK(r, 8'hFF)
    `CHK(erases, 3)
    `CHK(prog_mode, 1'b1)
    op(OP_EXIT, 8'h00, 1'b0);
    // Mode flag falls four clocks after the voltage drop, one after the host is ready
    #200 `CHK(prog_mode, 1'b0)
    end_sim;
  end
endmodule
